// ### core/step_pkg.sv
/*
 * Shared constants for the stepper phase counter and current regulation
 * logic: register offsets, field positions, reset values, encodings and
 * timing counts.
 * Assumes a single 250 MHz clock domain and a synchronous active-high reset.
 */
package step_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned T_BLANK_NS = 1000; // default blanking time
   localparam int unsigned T_FILT_NS = 500; // default comparator filter time
   // least times round up to whole cycles
   localparam int unsigned BLANK_CYC = (T_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned FILT_CYC = (T_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PWM_HZ = 20000; // default pwm frequency
   localparam int unsigned PWM_CYC = (CLK_MHZ * 1000000) / PWM_HZ;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PHASE = 8'h04;
   localparam logic [7:0] OFF_TIMING = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;

   // control register fields
   localparam int unsigned CTRL_ENERGIZE = 0;
   localparam int unsigned CTRL_PULSE_SEL = 1;
   localparam int unsigned CTRL_DIR = 2;
   localparam int unsigned CTRL_RES_LSB = 3;
   localparam int unsigned CTRL_AUTO_HOLD = 6;
   localparam int unsigned CTRL_HOLD = 7;
   localparam int unsigned CTRL_DECAY_LSB = 8;
   localparam int unsigned CTRL_ALT_SEL = 11;
   localparam int unsigned CTRL_ALT_RES_LSB = 12;
   localparam int unsigned CTRL_W = 15;
   localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;

   // timing register fields, in clock cycles
   localparam int unsigned TIM_BLANK_LSB = 0;
   localparam int unsigned TIM_FILT_LSB = 8;
   localparam logic [15:0] TIMING_RST = {FILT_CYC[7:0], BLANK_CYC[7:0]};

   localparam logic [5:0] PHASE_RST = 6'h00;

   // ------------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------------
   localparam logic [2:0] RES_16TH = 3'h0;
   localparam logic [2:0] RES_8TH = 3'h1;
   localparam logic [2:0] RES_MINI = 3'h2;
   localparam logic [2:0] RES_HALF = 3'h3;
   localparam logic [2:0] RES_FULL = 3'h4;
   localparam logic [5:0] FULL_OFFSET = 6'h08; // full steps sit at 8 mod 16

   localparam logic [1:0] DEC_SLOW = 2'h0;
   localparam logic [1:0] DEC_MIXED = 2'h1;
   localparam logic [1:0] DEC_AUTO_MIXED_A = 2'h2; // auto_mixed_decay_a
   localparam logic [1:0] DEC_AUTO_SLOW_TGT = 2'h3; // auto_slow_after_target_decay

   localparam logic [1:0] DRV_OFF = 2'h0;
   localparam logic [1:0] DRV_ON = 2'h1;
   localparam logic [1:0] DRV_FAST = 2'h2;
   localparam logic [1:0] DRV_SLOW = 2'h3;

endpackage : step_pkg

// ### core/regulation_timer.sv
/*
 * Per-phase current regulation sequencer: blanking, comparator filter,
 * minimum on-time and decay selection within one pwm cycle.
 * Assumes comparator inputs are synchronous to clk and pwm_start is a
 * one-cycle pulse marking each pwm cycle boundary.
 */
module regulation_timer #(
   parameter int unsigned CW = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pwm_start,
   input wire logic energize,
   input wire logic [1:0] decay_mode,
   input wire logic mixed_hint,
   input wire logic ref_update,
   input wire logic [7:0] tb,
   input wire logic [7:0] tft,
   input wire logic cmp_reg,
   input wire logic cmp_oc,
   input wire logic cmp_ls,
   output logic [1:0] drive,
   output logic oc_event
);

   typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_FAST, ST_SLOW} state_t;

   state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [7:0] filt_q, filt_d;
   logic tgt_q, tgt_d;
   logic [1:0] drive_d;
   logic oc_d;
   logic [CW-1:0] tb_total;
   logic past_blank;
   logic trig;
   logic filt_done;
   state_t decay_pick;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   assign tb_total = CW'(tb) + CW'(tft);
   // comparators are neglected until the blank count runs out
   assign past_blank = cnt_q >= CW'(tb);
   assign trig = (state_q == ST_FAST) ? (!cmp_ls || cmp_oc) : (cmp_reg || cmp_oc);
   // a zero filter setting still needs one qualified cycle
   assign filt_done = ({1'b0, filt_q} + 9'h001) >= {1'b0, tft};

   // decay style picked on each reference trip
   always_comb begin
      case (decay_mode)
         step_pkg::DEC_SLOW: decay_pick = ST_SLOW;
         step_pkg::DEC_MIXED: decay_pick = ST_FAST;
         step_pkg::DEC_AUTO_MIXED_A: decay_pick = mixed_hint ? ST_FAST : ST_SLOW;
         step_pkg::DEC_AUTO_SLOW_TGT: begin
            decay_pick = (mixed_hint && !tgt_q) ? ST_FAST : ST_SLOW;
         end
         default: decay_pick = ST_SLOW;
      endcase
   end

   always_comb begin
      state_d = state_q;
      cnt_d = (cnt_q == {CW{1'b1}}) ? cnt_q : cnt_q + CW'(1);
      filt_d = 8'h00;
      tgt_d = ref_update ? 1'b0 : tgt_q; // a new reference rearms auto mode two
      oc_d = 1'b0;
      if (!energize) begin
         state_d = ST_IDLE;
         cnt_d = '0;
      end else if (pwm_start) begin
         state_d = ST_ON;
         cnt_d = '0;
      end else begin
         case (state_q)
            ST_ON, ST_FAST: begin
               if (past_blank && trig) begin
                  filt_d = filt_q + 8'h01;
                  if (filt_done) begin
                     filt_d = 8'h00;
                     cnt_d = '0;
                     oc_d = cmp_oc;
                     if (cmp_oc || state_q == ST_FAST) begin
                        state_d = ST_SLOW; // low side sense ends fast decay
                     end else begin
                        state_d = decay_pick;
                        tgt_d = 1'b1;
                     end
                  end
               end
            end
            ST_SLOW, ST_IDLE: state_d = state_q;
            default: state_d = ST_IDLE;
         endcase
      end
      case (state_d)
         ST_ON: drive_d = step_pkg::DRV_ON;
         ST_FAST: drive_d = step_pkg::DRV_FAST;
         ST_SLOW: drive_d = step_pkg::DRV_SLOW;
         default: drive_d = step_pkg::DRV_OFF;
      endcase
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         filt_q <= 8'h00;
         tgt_q <= 1'b0;
         drive <= step_pkg::DRV_OFF;
         oc_event <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         filt_q <= filt_d;
         tgt_q <= tgt_d;
         drive <= drive_d;
         oc_event <= oc_d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_on_min_time: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_ON && energize && !pwm_start && cnt_q + CW'(1) < tb_total)
      |=> state_q == ST_ON)
      else $error("on phase left before blank plus filter time");

   a_fast_min_time: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_FAST && energize && !pwm_start && cnt_q + CW'(1) < tb_total)
      |=> state_q == ST_FAST)
      else $error("fast decay left before its minimum on time");

   a_blank_ignore: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_ON && !past_blank && energize && !pwm_start && cmp_oc)
      |=> (state_q == ST_ON && !oc_event))
      else $error("comparator honoured inside blanking");

   a_trip_decay: assert property (@(posedge clk) disable iff (rst)
      (state_q == ST_ON && energize && !pwm_start && past_blank && cmp_reg
       && !cmp_oc && filt_done && decay_mode == step_pkg::DEC_SLOW)
      |=> drive == step_pkg::DRV_SLOW)
      else $error("filtered reference trip did not start decay");

   a_auto_slow: assert property (@(posedge clk) disable iff (rst)
      (decay_mode == step_pkg::DEC_AUTO_SLOW_TGT && tgt_q && !ref_update
       && state_q == ST_ON) |=> state_q != ST_FAST)
      else $error("auto mode two used fast decay after target");

endmodule : regulation_timer

// ### core/stepper_phase_ctrl.sv
/*
 * Top of the stepper phase counter and current regulation logic: register
 * port, phase position counter, step resolution handling, stall hold and
 * two per-phase regulation sequencers.
 * Assumes all inputs are synchronous to REF_CLK, a register master that
 * never overlaps read and write strobes, and external comparators.
 */
module stepper_phase_ctrl #(
   parameter int unsigned PWM_CYCLES = step_pkg::PWM_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic STEP_PULSE_INPUT,
   input wire logic STALL_FLAG,
   input wire logic CMP_REG_A,
   input wire logic CMP_OC_A,
   input wire logic CMP_LS_A,
   input wire logic CMP_REG_B,
   input wire logic CMP_OC_B,
   input wire logic CMP_LS_B,
   output logic [5:0] PHASE_POSITION,
   output logic [5:0] REF_POSITION,
   output logic HOLD_MODE,
   output logic PWM_START,
   output logic [1:0] DRIVE_A,
   output logic [1:0] DRIVE_B,
   output logic OC_EVENT_A,
   output logic OC_EVENT_B
);

   localparam int unsigned PW = $clog2(PWM_CYCLES);

   logic [step_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [15:0] timing_q, timing_d;
   logic [5:0] pend_q, pend_d;
   logic [5:0] ref_d;
   logic [PW-1:0] pwm_cnt_q, pwm_cnt_d;
   logic pwm_tick_d;
   logic step_prev_q;
   logic ref_upd_q, ref_upd_d;
   logic [31:0] rdata_d;
   logic motor_energize;
   logic pulse_step_select;
   logic dir;
   logic [2:0] step_resolution;
   logic [1:0] decay_mode;
   logic freeze;
   logic step_edge;
   logic pin_step;
   logic mixed_a;
   logic mixed_b;

   // ------------------------------------------------------------------
   // position arithmetic
   // ------------------------------------------------------------------
   function automatic logic [5:0] step_size(input logic [2:0] res);
      case (res)
         step_pkg::RES_8TH: return 6'h02;
         step_pkg::RES_MINI: return 6'h04;
         step_pkg::RES_HALF: return 6'h08;
         step_pkg::RES_FULL: return 6'h10;
         default: return 6'h01;
      endcase
   endfunction : step_size

   // next position valid in res; a misaligned start snaps to the next grid
   // point, so the first move after a coarser change may be short
   function automatic logic [5:0] next_pos(input logic [5:0] p, input logic [2:0] res,
                                            input logic down);
      logic [5:0] s;
      logic [5:0] m;
      logic [5:0] off;
      logic [5:0] q;
      logic [5:0] r;
      s = step_size(res);
      m = s - 6'h01;
      off = (res == step_pkg::RES_FULL) ? step_pkg::FULL_OFFSET : 6'h00;
      q = p - off;
      if (!down) begin
         r = (q | m) + 6'h01;
      end else begin
         r = ((q & m) != 6'h00) ? (q & ~m) : q - s;
      end
      return r + off; // 6-bit sum wraps modulo 64
   endfunction : next_pos

   // serial full step: nearest full-step point along the spin direction
   function automatic logic [5:0] full_ref(input logic [5:0] p, input logic down);
      logic [5:0] q;
      logic [5:0] r;
      q = p - step_pkg::FULL_OFFSET;
      if (!down) begin
         r = ((q & 6'h0F) != 6'h00) ? ((q | 6'h0F) + 6'h01) : q;
      end else begin
         r = q & 6'h30;
      end
      return r + step_pkg::FULL_OFFSET;
   endfunction : full_ref

   // ------------------------------------------------------------------
   // control decode
   // ------------------------------------------------------------------
   assign motor_energize = ctrl_q[step_pkg::CTRL_ENERGIZE];
   assign pulse_step_select = ctrl_q[step_pkg::CTRL_PULSE_SEL];
   assign dir = ctrl_q[step_pkg::CTRL_DIR];
   assign decay_mode = ctrl_q[step_pkg::CTRL_DECAY_LSB +: 2];
   // the alternate resolution field lets software preload a second setting
   assign step_resolution = ctrl_q[step_pkg::CTRL_ALT_SEL]
      ? ctrl_q[step_pkg::CTRL_ALT_RES_LSB +: 3] : ctrl_q[step_pkg::CTRL_RES_LSB +: 3];
   assign freeze = ctrl_q[step_pkg::CTRL_AUTO_HOLD] && STALL_FLAG;
   // plain edge detect is enough: a 400 ns pulse spans 100 clocks
   assign step_edge = STEP_PULSE_INPUT && !step_prev_q;
   assign pin_step = pulse_step_select && step_edge && motor_energize && !freeze;
   // a coil is unwinding when its magnitude falls along the spin direction
   assign mixed_a = ~PHASE_POSITION[4] ^ dir;
   assign mixed_b = PHASE_POSITION[4] ^ dir;

   // ------------------------------------------------------------------
   // register port and phase counter, next values
   // ------------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      timing_d = timing_q;
      pend_d = pend_q;
      rdata_d = 32'h0000_0000;
      if (WR) begin
         case (ADDR)
            step_pkg::OFF_CTRL: ctrl_d = WDATA[step_pkg::CTRL_W-1:0];
            step_pkg::OFF_TIMING: timing_d = WDATA[15:0];
            step_pkg::OFF_PHASE: begin
               // serial writes land in the pending slot even unenergized
               if (!pulse_step_select && !freeze) begin
                  pend_d = WDATA[5:0];
               end
            end
            default: ctrl_d = ctrl_q; // unmapped writes are dropped
         endcase
      end
      if (pin_step) begin
         pend_d = next_pos(pend_q, step_resolution, dir);
      end
      // forced hold wins over a software clear in the same cycle
      if (freeze) begin
         ctrl_d[step_pkg::CTRL_HOLD] = 1'b1;
      end
      if (RD) begin
         case (ADDR)
            step_pkg::OFF_CTRL: rdata_d = 32'(ctrl_q);
            step_pkg::OFF_TIMING: rdata_d = 32'(timing_q);
            step_pkg::OFF_PHASE: rdata_d = 32'(PHASE_POSITION); // old value until applied
            step_pkg::OFF_STATUS: begin
               rdata_d = {18'h0_0000, DRIVE_B, DRIVE_A, 1'b0, STALL_FLAG, freeze,
                          HOLD_MODE, pend_q};
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // pwm boundary timer and the positions applied at each boundary
   always_comb begin
      pwm_tick_d = pwm_cnt_q == PW'(PWM_CYCLES - 1);
      pwm_cnt_d = pwm_tick_d ? '0 : pwm_cnt_q + PW'(1);
      ref_d = REF_POSITION;
      ref_upd_d = 1'b0;
      if (PWM_START && !freeze) begin
         if (!pulse_step_select && step_resolution == step_pkg::RES_FULL) begin
            ref_d = full_ref(pend_q, dir);
         end else begin
            ref_d = pend_q;
         end
         ref_upd_d = ref_d != REF_POSITION;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ctrl_q <= step_pkg::CTRL_RST;
         timing_q <= step_pkg::TIMING_RST;
         pend_q <= step_pkg::PHASE_RST;
         PHASE_POSITION <= step_pkg::PHASE_RST;
         REF_POSITION <= step_pkg::PHASE_RST;
         HOLD_MODE <= 1'b0;
         PWM_START <= 1'b0;
         pwm_cnt_q <= '0;
         step_prev_q <= 1'b0;
         ref_upd_q <= 1'b0;
         RDATA <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         timing_q <= timing_d;
         pend_q <= pend_d;
         if (PWM_START && !freeze) begin
            PHASE_POSITION <= pend_q;
         end
         REF_POSITION <= ref_d;
         HOLD_MODE <= ctrl_d[step_pkg::CTRL_HOLD];
         PWM_START <= pwm_tick_d;
         pwm_cnt_q <= pwm_cnt_d;
         step_prev_q <= STEP_PULSE_INPUT;
         ref_upd_q <= ref_upd_d;
         RDATA <= rdata_d;
      end
   end

   // ------------------------------------------------------------------
   // per-phase regulation
   // ------------------------------------------------------------------
   regulation_timer #(.CW(10)) reg_a (
      .clk(REF_CLK),
      .rst(RST),
      .pwm_start(PWM_START),
      .energize(motor_energize),
      .decay_mode(decay_mode),
      .mixed_hint(mixed_a),
      .ref_update(ref_upd_q),
      .tb(timing_q[step_pkg::TIM_BLANK_LSB +: 8]),
      .tft(timing_q[step_pkg::TIM_FILT_LSB +: 8]),
      .cmp_reg(CMP_REG_A),
      .cmp_oc(CMP_OC_A),
      .cmp_ls(CMP_LS_A),
      .drive(DRIVE_A),
      .oc_event(OC_EVENT_A)
   );

   regulation_timer #(.CW(10)) reg_b (
      .clk(REF_CLK),
      .rst(RST),
      .pwm_start(PWM_START),
      .energize(motor_energize),
      .decay_mode(decay_mode),
      .mixed_hint(mixed_b),
      .ref_update(ref_upd_q),
      .tb(timing_q[step_pkg::TIM_BLANK_LSB +: 8]),
      .tft(timing_q[step_pkg::TIM_FILT_LSB +: 8]),
      .cmp_reg(CMP_REG_B),
      .cmp_oc(CMP_OC_B),
      .cmp_ls(CMP_LS_B),
      .drive(DRIVE_B),
      .oc_event(OC_EVENT_B)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_pos_held_between: assert property (@(posedge REF_CLK) disable iff (RST)
      !PWM_START |=> $stable(PHASE_POSITION))
      else $error("phase position moved outside a pwm boundary");

   a_pos_applied: assert property (@(posedge REF_CLK) disable iff (RST)
      (PWM_START && !freeze) |=> PHASE_POSITION == $past(pend_q))
      else $error("pending position not applied at pwm boundary");

   a_pin_ignored_off: assert property (@(posedge REF_CLK) disable iff (RST)
      (pulse_step_select && !motor_energize && !WR) |=> $stable(pend_q))
      else $error("pulse edge moved position while unenergized");

   a_stall_freeze: assert property (@(posedge REF_CLK) disable iff (RST)
      freeze |=> (HOLD_MODE && $stable(PHASE_POSITION)))
      else $error("stall did not force hold and freeze position");

   a_full_grid: assert property (@(posedge REF_CLK) disable iff (RST)
      (pin_step && step_resolution == step_pkg::RES_FULL)
      |=> pend_q[3:0] == 4'h8)
      else $error("full step left the 8 mod 16 grid");

   a_fine_step_wrap: assert property (@(posedge REF_CLK) disable iff (RST)
      (pin_step && step_resolution == step_pkg::RES_16TH && !dir && pend_q == 6'h3F)
      |=> pend_q == 6'h00)
      else $error("phase position did not wrap past 63");

   a_half_down: assert property (@(posedge REF_CLK) disable iff (RST)
      (pin_step && step_resolution == step_pkg::RES_HALF && dir && pend_q[2:0] == 3'h0)
      |=> pend_q == $past(pend_q) - 6'h08)
      else $error("aligned half step down was not eight");

endmodule : stepper_phase_ctrl

// ### verif/step_host_model.sv
/* microcontroller side of the step pin: one pulse train unit per fire.
   assumes fire is a one-cycle request taken only while busy is low. */
module step_host_model #(
   parameter int unsigned HIGH_CYC = 250,
   parameter int unsigned PERIOD_CYC = 2500
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic fire,
   output logic pulse,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] cnt_q, cnt_d;
   logic busy_q, busy_d;

   // next state: count a whole period so back-to-back fires keep 100 kHz
   always_comb begin
      busy_d = busy_q;
      cnt_d = cnt_q;
      if (!busy_q) begin
         busy_d = fire;
         cnt_d = 12'h000;
      end else if (cnt_q == 12'(PERIOD_CYC - 1)) begin
         busy_d = 1'b0;
      end else begin
         cnt_d = cnt_q + 12'h001;
      end
   end

   always_ff @(posedge clk) begin
      busy_q <= rst ? 1'b0 : busy_d;
      cnt_q <= rst ? 12'h000 : cnt_d;
   end

   // high for 1 us, well above the 400 ns least width
   assign pulse = busy_q && (cnt_q < 12'(HIGH_CYC));
   assign busy = busy_q;
endmodule : step_host_model

// ### verif/stepper_phase_ctrl_tb.sv
/* self-checking bench for the phase counter and regulation top.
   assumes step_pkg is compiled first; a short pwm period keeps runs brief. */
module stepper_phase_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PWM = 64;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0, stall = 1'b0;
   logic pin, busy, hold, pwm_start, oc_a, oc_b;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, rv;
   logic [5:0] cmp = 6'h00, pos, refp, pexp;
   logic [2:0] rs;
   logic [1:0] drv_a, drv_b;
   int n_fail = 0, compares = 0, cyc = 0;

   always #2 clk = ~clk;

   stepper_phase_ctrl #(.PWM_CYCLES(PWM)) i_stepper_phase_ctrl (.REF_CLK(clk), .RST(rst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .STEP_PULSE_INPUT(pin),
      .STALL_FLAG(stall), .CMP_REG_A(cmp[0]), .CMP_OC_A(cmp[1]), .CMP_LS_A(cmp[2]),
      .CMP_REG_B(cmp[3]), .CMP_OC_B(cmp[4]), .CMP_LS_B(cmp[5]), .PHASE_POSITION(pos),
      .REF_POSITION(refp), .HOLD_MODE(hold), .PWM_START(pwm_start), .DRIVE_A(drv_a),
      .DRIVE_B(drv_b), .OC_EVENT_A(oc_a), .OC_EVENT_B(oc_b));
   step_host_model i_step_host_model (.clk(clk), .rst(rst), .fire(fire), .pulse(pin),
      .busy(busy));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // returns just after the edge that applies pending values
   task automatic wait_pwm();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (pwm_start !== 1'b1 && i < 200);
      @(posedge clk);
      #1;
   endtask : wait_pwm

   task automatic step_once();
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      #1 wait (busy === 1'b0);
   endtask : step_once

   // next grid point from p; an off-grid start snaps to the nearest point ahead
   function automatic logic [5:0] nxt(logic [5:0] p, logic [2:0] res, logic dn);
      logic [5:0] s, off, q;
      s = 6'h01 << ((res > 3'h4) ? 3'h0 : res);
      off = (res == 3'h4) ? 6'h08 : 6'h00;
      q = p - off;
      q = dn ? ((q + s - 6'h01) & ~(s - 6'h01)) - s : (q & ~(s - 6'h01)) + s;
      return q + off;
   endfunction : nxt

   function automatic logic [31:0] ctl(logic en, logic pm, logic dn, logic [2:0] r,
         logic [1:0] dec);
      return 32'(en) | (32'(pm) << step_pkg::CTRL_PULSE_SEL) | (32'(dn) << step_pkg::CTRL_DIR)
         | (32'(r) << step_pkg::CTRL_RES_LSB) | (32'(dec) << step_pkg::CTRL_DECAY_LSB);
   endfunction : ctl

   // reg comparator on phase a and overcurrent on phase b held high from the start;
   // mix says whether phase a is expected to pass through fast decay
   task automatic regulate(input logic [1:0] dec, input logic dn, input logic mix);
      int on_a, fast_a, on_b, oc;
      on_a = 0;
      fast_a = 0;
      on_b = 0;
      oc = 0;
      wr_reg(step_pkg::OFF_CTRL, ctl(1'b1, 1'b0, dn, 3'h0, dec));
      cmp <= 6'h11;
      wait_pwm();
      for (int i = 0; i < 40; i++) begin
         on_a += int'(drv_a === step_pkg::DRV_ON);
         fast_a += int'(drv_a === step_pkg::DRV_FAST);
         on_b += int'(drv_b === step_pkg::DRV_ON);
         // phase a sees no overcurrent, so any event there spoils the count
         oc += int'(oc_b === 1'b1) + 2 * int'(oc_a === 1'b1);
         @(posedge clk);
         #1;
      end
      chk(32'(on_a >= 12 && on_a <= 16), 32'h0000_0001);
      chk(32'(mix ? fast_a >= 12 && fast_a <= 16 : fast_a == 0), 32'h0000_0001);
      chk(drv_a, step_pkg::DRV_SLOW);
      chk(32'(on_b >= 12 && on_b <= 16), 32'h0000_0001);
      chk(32'(oc), 32'h0000_0001);
      chk(drv_b, step_pkg::DRV_SLOW);
      @(posedge clk);
      cmp <= 6'h00;
   endtask : regulate

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_reg(step_pkg::OFF_TIMING, rv);
      chk(rv, 32'h0000_7DFA);
      rd_reg(8'h10, rv);
      chk(rv, 32'h0000_0000);
      chk({hold, pos}, 7'h00);
      // serial write lands only at the pwm boundary, even unenergized
      wr_reg(step_pkg::OFF_PHASE, 32'h0000_0005);
      rd_reg(step_pkg::OFF_PHASE, rv);
      chk(rv, 32'h0000_0000);
      wait_pwm();
      chk({refp, pos}, 12'h145);
      // the boundary pulse comes back exactly one pwm period later
      repeat (PWM - 2) @(posedge clk);
      #1 chk(pwm_start, 1'b0);
      @(posedge clk);
      #1 chk(pwm_start, 1'b1);
      // pin stepping taken over at 5, a point of the 1/16 grid
      wr_reg(step_pkg::OFF_CTRL, ctl(1'b0, 1'b1, 1'b0, 3'h0, 2'h0));
      step_once();
      wait_pwm();
      chk(pos, 6'h05);
      // every resolution upward, full step down through the wrap, then an aligned
      // half step down and a snap back onto the full grid at 40
      pexp = 6'h05;
      for (int i = 0; i < 9; i++) begin
         rs = (i == 7) ? 3'h3 : (i > 4) ? 3'h4 : 3'(i);
         wr_reg(step_pkg::OFF_CTRL, ctl(1'b1, 1'b1, i > 4, rs, 2'h0));
         step_once();
         wait_pwm();
         pexp = nxt(pexp, rs, i > 4);
         chk({refp, pos}, {pexp, pexp});
      end
      // serial full step entered at 20, off the full-step grid, so the reference rounds up to 24
      wr_reg(step_pkg::OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h4, 2'h0));
      wr_reg(step_pkg::OFF_PHASE, 32'h0000_0014);
      wait_pwm();
      chk({refp, pos}, 12'h614);
      wr_reg(step_pkg::OFF_TIMING, 32'h0000_0408);
      regulate(step_pkg::DEC_SLOW, 1'b0, 1'b0);
      regulate(step_pkg::DEC_MIXED, 1'b0, 1'b1);
      // at 20 auto mode one mixes phase a only when spinning down; auto mode two
      // has already met its target there, so it stays slow
      regulate(step_pkg::DEC_AUTO_MIXED_A, 1'b1, 1'b1);
      regulate(step_pkg::DEC_AUTO_SLOW_TGT, 1'b1, 1'b0);
      // stall with auto hold: hold forced and position frozen
      wr_reg(step_pkg::OFF_CTRL, 32'h0000_0040);
      stall <= 1'b1;
      repeat (2) @(posedge clk);
      wr_reg(step_pkg::OFF_PHASE, 32'h0000_0021);
      wait_pwm();
      chk({hold, pos}, 7'h54);
      // refused write leaves pending at 20; hold, freeze and stall all show
      rd_reg(step_pkg::OFF_STATUS, rv);
      chk(rv, 32'h0000_01D4);
      give_verdict();
   end

   // hang guard well beyond the ten pulse periods and pwm waits
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end
endmodule : stepper_phase_ctrl_tb
